// ===== core/fifo_occupancy_state_machine.sv
// fifo occupancy control state machine
module fifo_occupancy_state_machine
  import fifo_ctl_pkg::*;
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               reset,
  // requests
  input  wire logic               push,
  input  wire logic               pop,
  input  wire logic [COUNT_W-1:0] count,
  // address counter and ram controls
  output wire logic               count_up,
  output wire logic               count_down,
  output wire logic               ram_write,
  output wire logic               ram_read,
  // occupancy flags
  output wire logic               empty_flag,
  output wire logic               full_flag,
  // state outputs
  output wire logic               state_empty,
  output wire logic               state_full,
  output wire logic               state_idle,
  output wire logic               state_draining,
  output wire logic               state_filling
);

  // ----------------------------------------
  // count decode
  // ----------------------------------------
  wire logic at_zero;
  wire logic at_full;
  wire logic below_full;
  wire logic above_zero;

  count_compare u_cmp (
    .count      (count),
    .at_zero    (at_zero),
    .at_full    (at_full),
    .below_full (below_full),
    .above_zero (above_zero)
  );

  // ----------------------------------------
  // counter and ram controls
  // ----------------------------------------
  // push and pop together drive both when count is 1 to 249; the counter nets them out itself
  assign count_up   = push & below_full;
  assign ram_write  = push & below_full;
  assign count_down = pop & above_zero;
  assign ram_read   = pop & above_zero;
  assign empty_flag = at_zero;
  assign full_flag  = at_full;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  fifo_state_t state;
  fifo_state_t next_state;
  wire logic   quiet;
  wire logic   pop_zero;
  wire logic   push_full;
  wire logic   push_room;
  wire logic   pop_some;

  assign quiet     = ~push & ~pop;
  assign pop_zero  = pop & at_zero;
  assign push_full = push & at_full;
  assign push_room = push & ~at_full;
  assign pop_some  = pop & ~at_zero;

  // earlier branches win over later ones within each state
  always_comb begin
    next_state = state;
    unique case (state)
      st_empty: begin
        if (push_room)      next_state = st_filling;
        else if (quiet)     next_state = st_idle;
      end
      st_full: begin
        if (quiet)          next_state = st_idle;
        else if (pop)       next_state = st_draining;
      end
      st_idle: begin
        if (pop_zero)       next_state = st_empty;
        else if (push_full) next_state = st_full;
        else if (pop_some)  next_state = st_draining;
        else if (push)      next_state = st_filling;
      end
      st_draining: begin
        if (quiet)          next_state = st_idle;
        else if (pop_zero)  next_state = st_empty;
        else if (push_room) next_state = st_filling;
        else if (pop_some)  next_state = st_draining;
        else if (push_full) next_state = st_full;
      end
      st_filling: begin
        if (quiet)          next_state = st_idle;
        else if (pop_zero)  next_state = st_empty;
        else if (push_room) next_state = st_filling;
        else if (push_full) next_state = st_full;
        else if (pop_some)  next_state = st_draining;
      end
      // unused codes recover to empty unconditionally
      default:              next_state = st_empty;
    endcase
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) state <= RESET_STATE;
    else       state <= next_state;
  end

  // ----------------------------------------
  // state outputs
  // ----------------------------------------
  wire logic [NUM_STATES-1:0] flags;

  state_flags u_flags (
    .clk        (clk),
    .reset      (reset),
    .next_state (next_state),
    .flags      (flags)
  );

  assign state_empty    = flags[st_empty];
  assign state_full     = flags[st_full];
  assign state_idle     = flags[st_idle];
  assign state_draining = flags[st_draining];
  assign state_filling  = flags[st_filling];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_push_up;
    @(posedge clk) disable iff (reset)
      (push && count < COUNT_FULL) |-> (count_up && ram_write);
  endproperty
  a_push_up: assert property (p_push_up) else $error("push below full not counted");

  property p_pop_down;
    @(posedge clk) disable iff (reset)
      (pop && count != COUNT_EMPTY) |-> (count_down && ram_read);
  endproperty
  a_pop_down: assert property (p_pop_down) else $error("pop above zero not counted");

  property p_full_stop;
    @(posedge clk) disable iff (reset)
      (count >= COUNT_FULL) |-> (!count_up && !ram_write);
  endproperty
  a_full_stop: assert property (p_full_stop) else $error("write at full");

  property p_empty_flag;
    @(posedge clk) disable iff (reset)
      (count == COUNT_EMPTY) |-> (empty_flag && !full_flag && !ram_read);
  endproperty
  a_empty_flag: assert property (p_empty_flag) else $error("empty flag wrong");

  property p_full_flag;
    @(posedge clk) disable iff (reset)
      (count == COUNT_FULL) |-> (full_flag && !empty_flag);
  endproperty
  a_full_flag: assert property (p_full_flag) else $error("full flag wrong");

  property p_reset;
    @(posedge clk)
      reset |=> (state_empty && !state_idle && !state_full && !state_filling);
  endproperty
  a_reset: assert property (p_reset) else $error("reset not to empty");

  property p_empty_push;
    @(posedge clk) disable iff (reset)
      (state_empty && push && count != COUNT_FULL) |=> state_filling;
  endproperty
  a_empty_push: assert property (p_empty_push) else $error("empty push missed");

  property p_full_pop;
    @(posedge clk) disable iff (reset)
      (state_full && pop) |=> state_draining;
  endproperty
  a_full_pop: assert property (p_full_pop) else $error("full pop missed");

  property p_idle_prio;
    @(posedge clk) disable iff (reset)
      (state_idle && pop && push && count == COUNT_EMPTY) |=> state_empty;
  endproperty
  a_idle_prio: assert property (p_idle_prio) else $error("idle priority wrong");

  property p_drain_quiet;
    @(posedge clk) disable iff (reset)
      (state_draining && !push && !pop) |=> state_idle;
  endproperty
  a_drain_quiet: assert property (p_drain_quiet) else $error("draining not idle");

  property p_fill_full;
    @(posedge clk) disable iff (reset)
      (state_filling && push && !pop && count == COUNT_FULL) |=> state_full;
  endproperty
  a_fill_full: assert property (p_fill_full) else $error("filling not full");

  property p_hold;
    @(posedge clk) disable iff (reset)
      (state_full && push && !pop) |=> $stable(flags);
  endproperty
  a_hold: assert property (p_hold) else $error("state moved with no condition");

  property p_onehot;
    @(posedge clk) disable iff (reset)
      $onehot(flags) && (flags[state] == 1'b1);
  endproperty
  a_onehot: assert property (p_onehot) else $error("state outputs not one-hot");

  property p_empty_quiet;
    @(posedge clk) disable iff (reset)
      (state_empty && !push && !pop) |=> state_idle;
  endproperty
  a_empty_quiet: assert property (p_empty_quiet) else $error("empty quiet missed");

  property p_empty_hold;
    @(posedge clk) disable iff (reset)
      (state_empty && !push && pop) |=> state_empty;
  endproperty
  a_empty_hold: assert property (p_empty_hold) else $error("empty did not hold");

  property p_full_quiet;
    @(posedge clk) disable iff (reset)
      (state_full && !push && !pop) |=> state_idle;
  endproperty
  a_full_quiet: assert property (p_full_quiet) else $error("full quiet missed");

  property p_idle_full;
    @(posedge clk) disable iff (reset)
      (state_idle && push && count == COUNT_FULL) |=> state_full;
  endproperty
  a_idle_full: assert property (p_idle_full) else $error("idle to full missed");

  property p_idle_drain;
    @(posedge clk) disable iff (reset)
      (state_idle && pop && count != COUNT_EMPTY && !(push && count == COUNT_FULL))
      |=> state_draining;
  endproperty
  a_idle_drain: assert property (p_idle_drain) else $error("idle to draining missed");

  property p_idle_fill;
    @(posedge clk) disable iff (reset)
      (state_idle && push && !pop && count != COUNT_FULL) |=> state_filling;
  endproperty
  a_idle_fill: assert property (p_idle_fill) else $error("idle to filling missed");

  property p_idle_hold;
    @(posedge clk) disable iff (reset)
      (state_idle && !push && !pop) |=> state_idle;
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("idle did not hold");

  property p_drain_empty;
    @(posedge clk) disable iff (reset)
      (state_draining && pop && count == COUNT_EMPTY) |=> state_empty;
  endproperty
  a_drain_empty: assert property (p_drain_empty) else $error("draining to empty");

  property p_drain_fill;
    @(posedge clk) disable iff (reset)
      (state_draining && push && count != COUNT_FULL && !(pop && count == COUNT_EMPTY))
      |=> state_filling;
  endproperty
  a_drain_fill: assert property (p_drain_fill) else $error("draining to filling");

  property p_drain_stay;
    @(posedge clk) disable iff (reset)
      (state_draining && pop && count != COUNT_EMPTY && !(push && count != COUNT_FULL))
      |=> state_draining;
  endproperty
  a_drain_stay: assert property (p_drain_stay) else $error("draining did not stay");

  property p_drain_full;
    @(posedge clk) disable iff (reset)
      (state_draining && push && !pop && count == COUNT_FULL) |=> state_full;
  endproperty
  a_drain_full: assert property (p_drain_full) else $error("draining to full");

  property p_fill_quiet;
    @(posedge clk) disable iff (reset)
      (state_filling && !push && !pop) |=> state_idle;
  endproperty
  a_fill_quiet: assert property (p_fill_quiet) else $error("filling quiet missed");

  property p_fill_empty;
    @(posedge clk) disable iff (reset)
      (state_filling && pop && count == COUNT_EMPTY) |=> state_empty;
  endproperty
  a_fill_empty: assert property (p_fill_empty) else $error("filling to empty");

  property p_fill_stay;
    @(posedge clk) disable iff (reset)
      (state_filling && push && count != COUNT_FULL && !(pop && count == COUNT_EMPTY))
      |=> state_filling;
  endproperty
  a_fill_stay: assert property (p_fill_stay) else $error("filling did not stay");

  property p_fill_drain;
    @(posedge clk) disable iff (reset)
      (state_filling && pop && !push && count != COUNT_EMPTY) |=> state_draining;
  endproperty
  a_fill_drain: assert property (p_fill_drain) else $error("filling to draining");

endmodule : fifo_occupancy_state_machine

// ===== include/fifo_ctl_pkg.sv
// constants and state encoding for the fifo occupancy controller
// How it works
// - push with count below 250 increments the counter and writes a byte
// - pop with count above 0 decrements the counter and reads a byte
// - empty flag is high whenever the count equals 0
// - full flag is high whenever the count equals 250
// - reset sends the machine to the empty state
// - empty: push and not 250 goes filling; no push, no pop goes idle
// - full: no push, no pop goes idle; pop goes draining
// - idle: pop at 0 empty, push at 250 full, pop draining, push filling
// - draining: quiet idle, pop at 0 empty, push and not 250 filling, pop stays, else full
// - filling: quiet idle, pop at 0 empty, push and not 250 stays, push at 250 full, pop draining
// - the earliest listed true condition of a state wins
// - a condition that is constant one is taken unconditionally
// - the occupancy count is an 8-bit unsigned value
// - reset is synchronous, active high; state outputs are registered
// - one output per state, high only in that state
package fifo_ctl_pkg;

  // ----------------------------------------
  // occupancy count
  // ----------------------------------------
  localparam int            COUNT_W     = 8;
  localparam logic [7:0]    COUNT_EMPTY = 8'h00;
  localparam logic [7:0]    COUNT_FULL  = 8'hfa;

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam int NUM_STATES = 5;

  typedef enum logic [2:0] {
    st_empty    = 3'h0,
    st_full     = 3'h1,
    st_idle     = 3'h2,
    st_draining = 3'h3,
    st_filling  = 3'h4
  } fifo_state_t;

  localparam fifo_state_t RESET_STATE = st_empty;

endpackage : fifo_ctl_pkg

// ===== core/count_compare.sv
// compares the occupancy count against the empty and full marks
module count_compare
  import fifo_ctl_pkg::*;
(
  // occupancy from the address counter
  input  wire logic [COUNT_W-1:0] count,
  // comparison results
  output wire logic               at_zero,
  output wire logic               at_full,
  output wire logic               below_full,
  output wire logic               above_zero
);

  // ----------------------------------------
  // compares
  // ----------------------------------------
  // unsigned on purpose: counts above the full mark never allow a push
  assign at_zero    = (count == COUNT_EMPTY);
  assign at_full    = (count == COUNT_FULL);
  assign below_full = (count <  COUNT_FULL);
  assign above_zero = (count >  COUNT_EMPTY);

endmodule : count_compare

// ===== core/state_flags.sv
// registered one-hot outputs, one per state
module state_flags
  import fifo_ctl_pkg::*;
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  // state about to be entered
  input  wire fifo_state_t           next_state,
  // one-hot flags
  output logic      [NUM_STATES-1:0] flags
);

  // ----------------------------------------
  // flag registers
  // ----------------------------------------
  // decoded from next_state so the flags line up with the state register
  for (genvar i = 0; i < NUM_STATES; i++) begin : g_flag
    wire logic hit;
    assign hit = (next_state == fifo_state_t'(i));
    always_ff @(posedge clk) begin
      if (reset) begin
        flags[i] <= (i == int'(RESET_STATE));
      end else begin
        flags[i] <= hit;
      end
    end
  end

endmodule : state_flags

// ===== test/fifo_mem_model.sv
// behavioural address counter and byte ram on the far side of the controller
module fifo_mem_model
  import fifo_ctl_pkg::*;
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               reset,
  // controls from the machine
  input  wire logic               count_up,
  input  wire logic               count_down,
  input  wire logic               ram_write,
  input  wire logic               ram_read,
  // bench preset of the occupancy
  input  wire logic               load,
  input  wire logic [COUNT_W-1:0] load_value,
  // occupancy and read data
  output logic      [COUNT_W-1:0] count,
  output logic      [7:0]         rd_data
);
  logic [7:0] mem [256];

  // preset wins so the bench can park the count at any corner
  always_ff @(posedge clk) begin
    if (reset) begin
      count <= 8'h00;
    end else if (load) begin
      count <= load_value;
    end else if (count_up && !count_down) begin
      count <= count + 8'h01;
    end else if (count_down && !count_up) begin
      count <= count - 8'h01;
    end
    if (ram_write) begin
      mem[count] <= count ^ 8'h5a;
    end
    // no read strobe: show a changing pattern, never the old byte
    rd_data <= ram_read ? mem[count - 8'h01] : ~rd_data;
  end
endmodule : fifo_mem_model

// ===== test/tb.sv
// self-checking bench for the fifo occupancy controller
module tb
  import fifo_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk = 1'b0;
  logic              reset, push, pop, load, armed = 1'b0;
  logic [7:0]        load_value, count;
  logic [15:0]       seed;
  logic              count_up, count_down, ram_write, ram_read, empty_flag, full_flag;
  logic              state_empty, state_full, state_idle, state_draining, state_filling;
  fifo_state_t       exp_state;
  logic [5:0]        exp_vec, got_vec;
  int                err_count = 0;
  int                check_count = 0;
  int                cycles = 0;
  logic [7:0]        corner [6] = '{8'h00, 8'h01, 8'hf9, 8'hfa, 8'hfb, 8'hff};

  always #12.5 clk = ~clk;

  fifo_occupancy_state_machine i_dut (.clk(clk), .reset(reset), .push(push), .pop(pop),
    .count(count), .count_up(count_up), .count_down(count_down), .ram_write(ram_write),
    .ram_read(ram_read), .empty_flag(empty_flag), .full_flag(full_flag),
    .state_empty(state_empty), .state_full(state_full), .state_idle(state_idle),
    .state_draining(state_draining), .state_filling(state_filling));

  fifo_mem_model i_mem (.clk(clk), .reset(reset), .count_up(count_up),
    .count_down(count_down), .ram_write(ram_write), .ram_read(ram_read), .load(load),
    .load_value(load_value), .count(count), .rd_data());

  // ----------------------------------------
  // expectation helpers
  // ----------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr

  function automatic fifo_state_t next_st(input fifo_state_t s, input logic pu,
                                          input logic po, input logic [7:0] c);
    logic q, z, f;
    q = !pu && !po;
    z = (c == 8'h00);
    f = (c == 8'hfa);
    next_st = s;
    case (s)
      st_empty:    if (pu && !f) next_st = st_filling; else if (q) next_st = st_idle;
      st_full:     if (q) next_st = st_idle; else if (po) next_st = st_draining;
      st_idle:     if (po && z) next_st = st_empty; else if (pu && f) next_st = st_full;
                   else if (po) next_st = st_draining; else if (pu) next_st = st_filling;
      st_draining: if (q) next_st = st_idle; else if (po && z) next_st = st_empty;
                   else if (pu && !f) next_st = st_filling; else if (pu && !po) next_st = st_full;
      st_filling:  if (q) next_st = st_idle; else if (po && z) next_st = st_empty;
                   else if (pu && f) next_st = st_full; else if (!pu) next_st = st_draining;
      default:     next_st = st_empty;
    endcase
  endfunction : next_st

  task automatic chk(input string name, input logic [5:0] exp, input logic [5:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // ----------------------------------------
  // checking at the falling edge, where all is settled
  // ----------------------------------------
  always @(negedge clk) begin
    if (armed) begin
      exp_vec = 6'h01 << exp_state;
      got_vec = {1'b0, state_filling, state_draining, state_idle, state_full, state_empty};
      chk("state", exp_vec, got_vec);
    end
    exp_vec = {push && count < COUNT_FULL, pop && count > COUNT_EMPTY,
               push && count < COUNT_FULL, pop && count > COUNT_EMPTY,
               count == COUNT_EMPTY, count == COUNT_FULL};
    got_vec = {count_up, count_down, ram_write, ram_read, empty_flag, full_flag};
    chk("controls", exp_vec, got_vec);
    exp_state = reset ? st_empty : next_st(exp_state, push, pop, count);
    armed = armed | reset;
  end

  task automatic step(input logic pu, input logic po);
    @(posedge clk);
    push <= pu;
    pop  <= po;
  endtask : step

  task automatic rstep(input int bias);
    seed = lfsr(seed);
    if (bias > 0) step(seed[0] | seed[1], seed[2] & seed[3]);
    else if (bias < 0) step(seed[2] & seed[3], seed[0] | seed[1]);
    else step(seed[0], seed[1]);
  endtask : rstep

  task end_sim;
    if (err_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim

  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      err_count++;
      end_sim;
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    reset = 1'b1; push = 1'b0; pop = 1'b0; load = 1'b0;
    load_value = 8'h00;
    seed = 16'h7d6a;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    // push-heavy traffic reaches and sits at full, pop-heavy drains to empty
    repeat (700) rstep(1);
    repeat (700) rstep(-1);
    foreach (corner[k]) begin
      @(posedge clk);
      load <= 1'b1;
      load_value <= corner[k];
      @(posedge clk);
      load <= 1'b0;
      repeat (20) rstep(0);
    end
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b0);
    // reset in mid-run while pushing
    @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    repeat (4) step(1'b1, 1'b1);
    repeat (2) @(posedge clk);
    end_sim;
  end
endmodule : tb
